// ### inc/bcnb_cfg.svh
/*
 Constants for the bit-clear and negative-branch execute block.
 Assumes inclusion by the design file only; the package does not include it.
*/
// Behaviour
// - Bit-clear opcode zeroes the indexed bit, other bits of the register kept.
// - Access flag 0 resolves the file address inside the fixed access bank.
// - Access flag 1 takes the bank from the bank select pointer.
// - Extended set, access 0, address up to 95 uses indexed literal offset.
// - Branch-on-negative opcode branches only when the negative flag is one.
// - Offset is signed 8-bit, doubled, then added to the program counter.
// - Taken target equals branch address plus two plus twice the offset.
// - Taken branch takes two cycles, second idle; not taken takes one.
`ifndef BCNB_CFG_SVH
`define BCNB_CFG_SVH
`define BCNB_OP_BCF_HI 4'h9
`define BCNB_OP_BN_HI 8'he6
`define BCNB_ILO_LIMIT 8'h5f
`define BCNB_ACCESS_SPLIT 8'h60
`define BCNB_ACCESS_HI_BANK 4'hf
`define BCNB_PC_STEP 21'h000002
`define BCNB_PC_RESET 21'h000000
`define BCNB_BYTE_ZERO 8'h00
`define BCNB_ADDR_ZERO 12'h000
`define BCNB_ACCESS_LO_BANK 4'h0
`define BCNB_ZERO_NIBBLE 4'h0
`define BCNB_SEXT_BITS 12
`define BCNB_BYTE_BITS 8
`define BCNB_OP4_MSB 15
`define BCNB_OP4_LSB 12
`define BCNB_OP8_MSB 15
`define BCNB_OP8_LSB 8
`define BCNB_BIT_MSB 11
`define BCNB_BIT_LSB 9
`define BCNB_ACC_POS 8
`define BCNB_FA_MSB 7
`define BCNB_FA_LSB 0
`endif

// ### inc/bcnb_pkg.sv
/*
 Types for the bit-clear and negative-branch execute block.
 Assumes the constants header is on the include path.
*/
package bcnb_pkg;
   typedef logic [20:0] bcnb_pc_t;
   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [7:0] data;
   } bcnb_wr_s;
   typedef enum logic [1:0] {
      BCNB_RUN = 2'h1,
      BCNB_IDLE = 2'h2
   } bcnb_state_e;
endpackage

// ### hdl/bcnb_core.sv
/*
 Execute stage for the bit clear in file and branch when sign set instructions.
 Assumes the fetch unit presents one word per cycle with instr_valid, and data
 memory answers rd_data combinationally for rd_addr in the same cycle.
*/
`timescale 1ns/1ps
`include "bcnb_cfg.svh"
// One data bit of the bit clear; the lane whose number matches the index is forced low.
module bcnb_lane
#(
   parameter logic [2:0] LANE = 3'h0
)
(
   input wire logic data_in,
   input wire logic [2:0] bit_idx,
   input wire logic clear_en,
   output logic data_out
);
   wire logic hit;

   assign hit = clear_en && (bit_idx == LANE);
   assign data_out = data_in && !hit;
endmodule // bcnb_lane

module bcnb_core
   import bcnb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [3:0] bank_select_pointer,
   input wire logic [11:0] index_base,
   input wire logic ext_set_en,
   input wire logic flag_negative,
   input wire logic [7:0] rd_data,
   output logic [11:0] rd_addr,
   output bcnb_wr_s wr_reg,
   output bcnb_pc_t pc_reg,
   output logic busy_reg,
   output logic branch_taken_reg
);
   bcnb_state_e state_reg;
   bcnb_state_e state_next;
   bcnb_wr_s wr_next;
   bcnb_pc_t pc_next;
   logic busy_next;
   logic taken_next;

   // Decoded fields of the presented word.
   wire logic run;
   wire logic [3:0] op_hi4;
   wire logic [7:0] op_hi8;
   wire logic is_bcf;
   wire logic is_bn;
   wire logic [2:0] bit_idx;
   wire logic acc;
   wire logic [7:0] faddr;

   assign run = (state_reg == BCNB_RUN) && instr_valid;
   assign op_hi4 = instr_word[`BCNB_OP4_MSB:`BCNB_OP4_LSB];
   assign op_hi8 = instr_word[`BCNB_OP8_MSB:`BCNB_OP8_LSB];
   assign is_bcf = run && (op_hi4 == `BCNB_OP_BCF_HI);
   assign is_bn = run && (op_hi8 == `BCNB_OP_BN_HI);
   assign bit_idx = instr_word[`BCNB_BIT_MSB:`BCNB_BIT_LSB];
   assign acc = instr_word[`BCNB_ACC_POS];
   assign faddr = instr_word[`BCNB_FA_MSB:`BCNB_FA_LSB];

   // Address resolution for the bit clear.
   wire logic ilo;
   wire logic [11:0] ilo_addr;
   wire logic acc_low;
   wire logic [3:0] acc_bank;
   wire logic [11:0] access_addr;
   wire logic [11:0] banked_addr;
   wire logic [11:0] direct_addr;
   wire logic [11:0] eff_addr;

   assign ilo = ext_set_en && !acc && (faddr <= `BCNB_ILO_LIMIT);
   // The indexed sum wraps at the top of data memory; software must keep the base in range.
   assign ilo_addr = index_base + {`BCNB_ZERO_NIBBLE, faddr};
   assign acc_low = (faddr < `BCNB_ACCESS_SPLIT);
   assign acc_bank = acc_low ? `BCNB_ACCESS_LO_BANK : `BCNB_ACCESS_HI_BANK;
   assign access_addr = {acc_bank, faddr};
   assign banked_addr = {bank_select_pointer, faddr};
   assign direct_addr = acc ? banked_addr : access_addr;
   assign eff_addr = ilo ? ilo_addr : direct_addr;

   // Read address is combinational so the modify lands in the same cycle; wr_reg presents the write after the next edge.
   assign rd_addr = is_bcf ? eff_addr : `BCNB_ADDR_ZERO;

   // Modify step: one lane per data bit.
   wire logic [7:0] cleared;

   for (genvar i = 0; i < `BCNB_BYTE_BITS; i++) begin : g_lane
      bcnb_lane #(
         .LANE(3'(i))
      ) u_lane (
         .data_in(rd_data[i]),
         .bit_idx(bit_idx),
         .clear_en(is_bcf),
         .data_out(cleared[i])
      );
   end

   // Branch arithmetic.
   wire logic take;
   wire bcnb_pc_t off2;
   wire bcnb_pc_t pc_inc;
   wire bcnb_pc_t target;

   assign take = is_bn && flag_negative;
   assign off2 = {{`BCNB_SEXT_BITS{faddr[`BCNB_FA_MSB]}}, faddr, 1'b0};
   assign pc_inc = pc_reg + `BCNB_PC_STEP;
   assign target = pc_inc + off2;

   always_comb begin
      wr_next = '0;
      wr_next.we = is_bcf;
      wr_next.addr = eff_addr;
      wr_next.data = is_bcf ? cleared : `BCNB_BYTE_ZERO;
   end

   always_comb begin
      pc_next = pc_reg;
      state_next = state_reg;
      case (state_reg)
         BCNB_RUN: begin
            if (take) begin
               pc_next = target;
               state_next = BCNB_IDLE;
            end else if (run) begin
               pc_next = pc_inc;
            end
         end
         BCNB_IDLE: begin
            state_next = BCNB_RUN;
         end
         default: begin
            state_next = BCNB_RUN;
         end
      endcase
   end

   // A word presented during the idle cycle is dropped; the fetch unit must hold it.
   assign busy_next = (state_next == BCNB_IDLE);
   assign taken_next = take;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= BCNB_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= `BCNB_PC_RESET;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // No flag output exists, so neither instruction can disturb status.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
      end else begin
         wr_reg <= wr_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         branch_taken_reg <= 1'b0;
      end else begin
         branch_taken_reg <= taken_next;
      end
   end
endmodule // bcnb_core

// ### bench/bcnb_mem.sv
/* Data memory model for bcnb_core.
 Answers rd_addr within the same cycle. */
`timescale 1ns/1ps
module bcnb_mem (
   input wire logic [11:0] rd_addr,
   output logic [7:0] rd_data
);
   assign rd_data = rd_addr[7:0] ^ rd_addr[11:4];
endmodule // bcnb_mem

// ### bench/bcnb_checker.sv
/* Assertions on bcnb_core ports.
 Bound to each instance of that module. */
`timescale 1ns/1ps
module bcnb_checker import bcnb_pkg::*; (input logic clk_sys, rst_n, instr_valid, ext_set_en, flag_negative,
   busy_reg, branch_taken_reg, input logic [15:0] instr_word, input logic [3:0] bank_select_pointer,
   input logic [11:0] index_base, rd_addr, input logic [7:0] rd_data, input bcnb_wr_s wr_reg, input bcnb_pc_t pc_reg);
   wire [7:0] f = instr_word[7:0];
   wire a = instr_word[8], k = instr_valid & !busy_reg, c = k & instr_word[15:12] == 4'h9;
   wire b = k & instr_word[15:8] == 8'he6, t = b & flag_negative, l = f < 8'h60;
   wire [20:0] o = {{12{f[7]}}, f, 1'b0}, e = {1'b1, rd_addr, rd_data & ~(8'h01 << instr_word[11:9])};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_clear_bit: assert property (c |=> wr_reg == $past(e)) else $error("clr");
   a_access_bank: assert property (c & !a & !(ext_set_en & l) |-> rd_addr == {l ? 4'h0 : 4'hf, f})
      else $error("acc");
   a_bank_pointer: assert property (c & a |-> rd_addr == {bank_select_pointer, f}) else $error("bsp");
   a_indexed_offset: assert property (c & !a & ext_set_en & l |-> rd_addr == index_base + {4'h0, f})
      else $error("ilo");
   a_taken_target: assert property (t |=> pc_reg == $past(pc_reg) + 21'h2 + $past(o)) else $error("tgt");
   a_fall_through: assert property (b & !t |=> pc_reg == $past(pc_reg) + 21'h2) else $error("nt");
   a_idle_cycle: assert property (t |=> busy_reg & branch_taken_reg ##1 !busy_reg) else $error("idle");
   a_no_write: assert property (!c |=> !wr_reg.we) else $error("we");
endmodule // bcnb_checker
bind bcnb_core bcnb_checker chk(.*);

// ### bench/testbench.sv
/* Random bench for bcnb_core.
 Uses bcnb_mem and the bound checker. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin fails++; $display("BAD %s %h %h", n, e, s); end end
module testbench import bcnb_pkg::*;;
   logic clk_sys = 0, rst_n = 0, w = 0, busy, t = 0, tk;
   logic [11:0] ea = 0;
   logic [7:0] ed = 0;
   logic [31:0] r, q = 0;
   logic [11:0] ra;
   logic [7:0] rd;
   bcnb_wr_s wr;
   bcnb_pc_t pc, p = 0;
   int fails = 0, tests_run = 0, seed = 32'h0f034c4f;
   bcnb_core dut(.clk_sys, .rst_n, .instr_valid(q[17] | q[16]), .instr_word(q[15:0]), .bank_select_pointer(q[25:22]),
      .index_base(q[31:20]), .ext_set_en(q[21]), .flag_negative(q[20]), .rd_data(rd), .rd_addr(ra), .wr_reg(wr),
      .pc_reg(pc), .busy_reg(busy), .branch_taken_reg(tk));
   bcnb_mem mem(.rd_addr(ra), .rd_data(rd));
   function bcnb_pc_t step(logic [31:0] x);
      return 21'h2 + (x[15:8] == 8'he6 && x[20] ? {{12{x[7]}}, x[7:0], 1'b0} : 21'h0);
   endfunction
   function logic [11:0] fa(logic [31:0] x);
      if (x[21] && !x[8] && x[7:0] <= 8'h5f) return x[31:20] + {4'h0, x[7:0]};
      return x[8] ? {x[25:22], x[7:0]} : {x[7:0] < 8'h60 ? 4'h0 : 4'hf, x[7:0]};
   endfunction
   task close_out;
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial forever #50 clk_sys = ~clk_sys;
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1;
      for (int i = 0; i < 900; i++) begin
         @(posedge clk_sys);
         r = i == 0 ? 32'h0025005f : i == 1 ? 32'h00190080 : $random(seed);
         q <= {r[31:16], r[19:18] == 0 ? r[15:0] : r[19] ? {8'he6, r[7:0]} : {4'h9, r[11:0]}};
         #1;
         `CHK("pc", p, pc)
         `CHK("we", w, wr.we)
         `CHK("tk", t, tk)
         if (w) `CHK("wa", ea, wr.addr)
         if (w) `CHK("wd", ed, wr.data)
         w = (q[17] | q[16]) && !busy;
         t = w && q[15:8] == 8'he6 && q[20];
         if (w) p = p + step(q);
         w = w && q[15:12] == 4'h9;
         ea = fa(q);
         ed = (ea[7:0] ^ ea[11:4]) & ~(8'h01 << q[11:9]);
      end
      close_out;
   end
endmodule // testbench
